// [rtl/tpr_top.sv]
// Test access port reset, mode latch and identity register.
// Assumes test pins are asynchronous, test clock far slower than REF_CLK.
// Operation
// - Device reset resets core side; test reset resets test and emulation logic.
// - Core boots on device reset release; test reset may stay asserted forever.
// - Identity variant valid only after device reset; other instructions always work.
// - Test reset input reads asserted when undriven, via internal pulldown.
// - After device reset release, test reset rising edge latches mode pins.
// - Read-only 32-bit identity register at its fixed memory address.
// - Identity holds 4-bit variant, 16-bit part, 11-bit maker code.
// - Identity bit zero always reads one.
`timescale 1ns/1ns
`default_nettype none
module tpr_top (
    // Clock and synchronous reset
    input wire logic REF_CLK,
    input wire logic RESET,
    // Device reset pin, active low
    input wire logic DEV_RESET_N,
    // Test port pins
    input wire logic TEST_PORT_CLOCK,
    input wire logic TEST_RESET_N,
    input wire logic TEST_RESET_DRIVEN,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE,
    input wire logic [1:0] MODE_SELECT_PINS,
    // Status to the rest of the chip
    output logic CORE_RUN,
    output logic EMU_IN_RESET,
    output logic [1:0] MODE_LATCHED,
    output logic MODE_VALID,
    // Register port
    input wire logic [31:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA
);
    typedef struct packed {
        tpr_pkg::tpr_state_e st;
        logic tck;
        logic trst_n;
        logic [tpr_pkg::TPR_IR_W-1:0] ir_sh;
        logic [tpr_pkg::TPR_IR_W-1:0] ir;
        logic [31:0] dr_sh;
        logic tdo;
        logic tdo_oe;
        logic [1:0] mode;
        logic mode_ok;
        logic [31:0] rdata;
    } tpr_top_s;
    tpr_top_s r_q, r_d;

    logic [6:0] pins_s;
    logic tck_s, trst_raw_s, tms_s, tdi_s, dev_rst_n_s;
    logic [1:0] emu_s;
    logic trst_pin;
    logic tck_rise, tck_fall, trst_rise;

    // Undriven test reset pin is pulled low
    assign trst_pin = TEST_RESET_DRIVEN & TEST_RESET_N;

    tpr_sync #(.W(7)) u_sync (
        .clk(REF_CLK),
        .rst(RESET),
        .d({TEST_PORT_CLOCK, trst_pin, TMS, TDI, DEV_RESET_N, MODE_SELECT_PINS}),
        .q(pins_s)
    );
    assign {tck_s, trst_raw_s, tms_s, tdi_s, dev_rst_n_s, emu_s} = pins_s;

    assign tck_rise = tck_s & ~r_q.tck;
    assign tck_fall = ~tck_s & r_q.tck;
    // Test reset is honoured only on test clock rises, so it needs the clock
    assign trst_rise = tck_rise & trst_raw_s & ~r_q.trst_n;

    always_comb begin
        r_d = r_q;
        r_d.tck = tck_s;
        r_d.rdata = 32'h0;
        if (tck_rise) begin
            r_d.trst_n = trst_raw_s;
        end
        // Mode pins latched on test reset rise, only with core out of reset
        if (trst_rise && dev_rst_n_s) begin
            r_d.mode = emu_s;
            r_d.mode_ok = 1'b1;
        end
        // Reset acts on the rise that samples it low, so the driver drops on that same edge
        if ((!r_q.trst_n && !(tck_rise && trst_raw_s)) || (tck_rise && !trst_raw_s)) begin
            // Held test reset keeps port and emulation logic parked
            r_d.st = tpr_pkg::TPR_TLR;
            r_d.ir = tpr_pkg::TPR_IR_RESET;
            r_d.tdo_oe = 1'b0;
        end else if (tck_rise) begin
            // Standard controller transitions on test clock rise
            case (r_q.st)
                tpr_pkg::TPR_TLR: r_d.st = tms_s ? tpr_pkg::TPR_TLR : tpr_pkg::TPR_RTI;
                tpr_pkg::TPR_RTI: r_d.st = tms_s ? tpr_pkg::TPR_SDS : tpr_pkg::TPR_RTI;
                tpr_pkg::TPR_SDS: r_d.st = tms_s ? tpr_pkg::TPR_SIS : tpr_pkg::TPR_CDR;
                tpr_pkg::TPR_CDR: r_d.st = tms_s ? tpr_pkg::TPR_E1DR : tpr_pkg::TPR_SHDR;
                tpr_pkg::TPR_SHDR: r_d.st = tms_s ? tpr_pkg::TPR_E1DR : tpr_pkg::TPR_SHDR;
                tpr_pkg::TPR_E1DR: r_d.st = tms_s ? tpr_pkg::TPR_UDR : tpr_pkg::TPR_PDR;
                tpr_pkg::TPR_PDR: r_d.st = tms_s ? tpr_pkg::TPR_E2DR : tpr_pkg::TPR_PDR;
                tpr_pkg::TPR_E2DR: r_d.st = tms_s ? tpr_pkg::TPR_UDR : tpr_pkg::TPR_SHDR;
                tpr_pkg::TPR_UDR: r_d.st = tms_s ? tpr_pkg::TPR_SDS : tpr_pkg::TPR_RTI;
                tpr_pkg::TPR_SIS: r_d.st = tms_s ? tpr_pkg::TPR_TLR : tpr_pkg::TPR_CIR;
                tpr_pkg::TPR_CIR: r_d.st = tms_s ? tpr_pkg::TPR_E1IR : tpr_pkg::TPR_SHIR;
                tpr_pkg::TPR_SHIR: r_d.st = tms_s ? tpr_pkg::TPR_E1IR : tpr_pkg::TPR_SHIR;
                tpr_pkg::TPR_E1IR: r_d.st = tms_s ? tpr_pkg::TPR_UIR : tpr_pkg::TPR_PIR;
                tpr_pkg::TPR_PIR: r_d.st = tms_s ? tpr_pkg::TPR_E2IR : tpr_pkg::TPR_PIR;
                tpr_pkg::TPR_E2IR: r_d.st = tms_s ? tpr_pkg::TPR_UIR : tpr_pkg::TPR_SHIR;
                tpr_pkg::TPR_UIR: r_d.st = tms_s ? tpr_pkg::TPR_SDS : tpr_pkg::TPR_RTI;
                default: r_d.st = tpr_pkg::TPR_TLR;
            endcase
            case (r_q.st)
                tpr_pkg::TPR_TLR: r_d.ir = tpr_pkg::TPR_IR_RESET;
                // Identity capture works whatever the core reset; variant needs core up
                tpr_pkg::TPR_CDR: r_d.dr_sh = (r_q.ir == tpr_pkg::TPR_IR_BYPASS) ? 32'h0
                                              : tpr_pkg::tpr_id_word(dev_rst_n_s);
                tpr_pkg::TPR_SHDR: r_d.dr_sh = (r_q.ir == tpr_pkg::TPR_IR_BYPASS)
                                               ? {31'h0, tdi_s} : {tdi_s, r_q.dr_sh[31:1]};
                tpr_pkg::TPR_CIR: r_d.ir_sh = tpr_pkg::TPR_IR_CAPT;
                tpr_pkg::TPR_SHIR: r_d.ir_sh = {tdi_s, r_q.ir_sh[tpr_pkg::TPR_IR_W-1:1]};
                tpr_pkg::TPR_UIR: r_d.ir = r_q.ir_sh;
                default: r_d.ir = r_q.ir;
            endcase
        end
        // Output changes on test clock fall, driven only while shifting
        if (tck_fall) begin
            r_d.tdo_oe = (r_q.st == tpr_pkg::TPR_SHDR) || (r_q.st == tpr_pkg::TPR_SHIR);
            r_d.tdo = (r_q.st == tpr_pkg::TPR_SHIR) ? r_q.ir_sh[0] : r_q.dr_sh[0];
        end
        // Identity read-only; writes ignored
        if (RD && ADDR == tpr_pkg::TPR_ID_ADDR) begin
            r_d.rdata = tpr_pkg::tpr_id_word(dev_rst_n_s);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            r_q.st <= tpr_pkg::TPR_TLR;
            r_q.tck <= 1'b0;
            r_q.trst_n <= 1'b0;
            r_q.ir_sh <= '0;
            r_q.ir <= tpr_pkg::TPR_IR_RESET;
            r_q.dr_sh <= 32'h0;
            r_q.tdo <= 1'b0;
            r_q.tdo_oe <= 1'b0;
            r_q.mode <= tpr_pkg::TPR_MODE_RESET;
            r_q.mode_ok <= 1'b0;
            r_q.rdata <= 32'h0;
        end else begin
            r_q <= r_d;
        end
    end

    // Core runs on device reset alone, test reset state irrelevant
    assign CORE_RUN = dev_rst_n_s;
    assign EMU_IN_RESET = ~r_q.trst_n;
    assign MODE_LATCHED = r_q.mode;
    assign MODE_VALID = r_q.mode_ok;
    assign TDO = r_q.tdo;
    assign TDO_OE = r_q.tdo_oe;
    assign RDATA = r_q.rdata;
endmodule : tpr_top
`default_nettype wire

// [rtl/tpr_pkg.sv]
// Package for the test port reset and identity block.
// Assumes a 125 MHz core clock and a slow external test clock sampled by it.
package tpr_pkg;
    // Identity register, memory-mapped byte address
    localparam logic [31:0] TPR_ID_ADDR = 32'h01B3F008;
    // Identity field positions
    localparam int TPR_VAR_LSB = 28;
    localparam int TPR_PART_LSB = 12;
    localparam int TPR_MFR_LSB = 1;
    // Identity values, arbitrary neutral codes
    localparam logic [3:0] TPR_VARIANT = 4'h1;
    localparam logic [15:0] TPR_PART = 16'h1234;
    localparam logic [10:0] TPR_MFR = 11'h055;
    // Instruction register
    localparam int TPR_IR_W = 4;
    localparam logic [TPR_IR_W-1:0] TPR_IR_RESET = 4'h1;
    localparam logic [TPR_IR_W-1:0] TPR_IR_IDCODE = 4'h1;
    localparam logic [TPR_IR_W-1:0] TPR_IR_BYPASS = 4'hF;
    localparam logic [TPR_IR_W-1:0] TPR_IR_CAPT = 4'h1;
    // Latched mode encodings
    localparam logic [1:0] TPR_MODE_RESET = 2'h3;

    typedef enum logic [15:0] {
        TPR_TLR = 16'h0001, TPR_RTI = 16'h0002, TPR_SDS = 16'h0004, TPR_CDR = 16'h0008,
        TPR_SHDR = 16'h0010, TPR_E1DR = 16'h0020, TPR_PDR = 16'h0040, TPR_E2DR = 16'h0080,
        TPR_UDR = 16'h0100, TPR_SIS = 16'h0200, TPR_CIR = 16'h0400, TPR_SHIR = 16'h0800,
        TPR_E1IR = 16'h1000, TPR_PIR = 16'h2000, TPR_E2IR = 16'h4000, TPR_UIR = 16'h8000
    } tpr_state_e;

    // Identity word, variant blanked while the core sits in reset
    function automatic logic [31:0] tpr_id_word(input logic core_up);
        tpr_id_word = {(core_up ? TPR_VARIANT : 4'h0), TPR_PART, TPR_MFR, 1'b1};
    endfunction : tpr_id_word
endpackage : tpr_pkg

// [rtl/tpr_sync.sv]
// Two-flop synchroniser for a bundle of pin levels.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module tpr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } tpr_sync_s;
    tpr_sync_s r_q, r_d;

    always_comb begin
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign q = r_q.s2;
endmodule : tpr_sync
`default_nettype wire

// [verif/tpr_checker.sv]
// Assertions on the test port block ports.
// Assumes binding to tpr_top, one clock domain.
`timescale 1ns/1ns
`default_nettype none
module tpr_checker (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RESET,
    // Inputs
    input wire logic DEV_RESET_N,
    input wire logic TEST_RESET_N,
    input wire logic TEST_RESET_DRIVEN,
    input wire logic [31:0] ADDR,
    input wire logic RD,
    // Outputs
    input wire logic TDO_OE,
    input wire logic CORE_RUN,
    input wire logic EMU_IN_RESET,
    input wire logic [1:0] MODE_LATCHED,
    input wire logic MODE_VALID,
    input wire logic [31:0] RDATA
);
    logic id_rd_q;
    always_ff @(posedge REF_CLK) id_rd_q <= RD && ADDR == tpr_pkg::TPR_ID_ADDR;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    a_rdata_idle: assert property (!id_rd_q |-> RDATA == 32'h0) else $error("stray data");
    a_id_fields: assert property (id_rd_q |-> RDATA[27:0] == {tpr_pkg::TPR_PART, tpr_pkg::TPR_MFR, 1'b1})
        else $error("id fields");
    a_id_variant: assert property (id_rd_q |-> RDATA[31:28] == ($past(CORE_RUN) ? tpr_pkg::TPR_VARIANT : 4'h0))
        else $error("id variant");
    a_core_boot: assert property (DEV_RESET_N [*3] |-> CORE_RUN) else $error("no boot");
    a_emu_release: assert property ($fell(EMU_IN_RESET) |-> TEST_RESET_N && TEST_RESET_DRIVEN)
        else $error("bad release");
    a_mode_default: assert property (!MODE_VALID |-> MODE_LATCHED == 2'h3) else $error("mode default");
    a_mode_sticky: assert property (MODE_VALID |=> MODE_VALID) else $error("mode lost");
    a_oe_idle: assert property (EMU_IN_RESET |-> !TDO_OE) else $error("drive in reset");
endmodule : tpr_checker
bind tpr_top tpr_checker u_chk (.REF_CLK(REF_CLK), .RESET(RESET), .DEV_RESET_N(DEV_RESET_N),
    .TEST_RESET_N(TEST_RESET_N), .TEST_RESET_DRIVEN(TEST_RESET_DRIVEN), .ADDR(ADDR), .RD(RD), .TDO_OE(TDO_OE),
    .CORE_RUN(CORE_RUN), .EMU_IN_RESET(EMU_IN_RESET), .MODE_LATCHED(MODE_LATCHED), .MODE_VALID(MODE_VALID),
    .RDATA(RDATA));
`default_nettype wire

// [verif/tpr_jtag_model.sv]
// Test controller model driving the test pins.
// Assumes clk is the core clock; test clock idles low between calls.
`timescale 1ns/1ns
`default_nettype none
module tpr_jtag_model (
    // Pacing clock
    input wire logic clk,
    // Test pins
    output logic tck,
    output logic trst_n,
    output logic trst_drv,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial {tck, trst_n, trst_drv, tms, tdi} = 5'h06;
    // Undriven wire shown high, so only the pulldown can hold reset
    task automatic pins(input logic n, input logic drv);
        trst_n <= n;
        trst_drv <= drv;
    endtask : pins
    // One 80 ns period, also run while test reset is low
    task automatic step(input logic m, input logic d, output logic o);
        tms <= m;
        tdi <= d;
        @(posedge clk);
        tck <= 1'b1;
        repeat (4) @(posedge clk);
        tck <= 1'b0;
        repeat (5) @(posedge clk);
        o = tdo;
    endtask : step
endmodule : tpr_jtag_model
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the test port block.
// Assumes design, checker and controller model compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0, reset = 1'b1, dev_n = 1'b0, wr = 1'b0, rd = 1'b0, tdo, tdo_oe, core, emu, mv, o;
    logic tck, trst_n, trst_drv, tms, tdi, tdi_hi = 1'b0;
    logic [1:0] msel = 2'h1, mode;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, d, got;
    logic [31:0] id_up = {tpr_pkg::TPR_VARIANT, tpr_pkg::TPR_PART, tpr_pkg::TPR_MFR, 1'b1};
    int mismatches = 0, n_compared = 0, cycles = 0;
    tpr_top DUT (.REF_CLK(ref_clk), .RESET(reset), .DEV_RESET_N(dev_n), .TEST_PORT_CLOCK(tck), .TEST_RESET_N(trst_n),
        .TEST_RESET_DRIVEN(trst_drv), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe), .MODE_SELECT_PINS(msel),
        .CORE_RUN(core), .EMU_IN_RESET(emu), .MODE_LATCHED(mode), .MODE_VALID(mv), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata));
    tpr_jtag_model jm (.clk(ref_clk), .tck(tck), .trst_n(trst_n), .trst_drv(trst_drv), .tms(tms), .tdi(tdi), .tdo(tdo));
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [31:0] a);
        @(posedge ref_clk);
        {wr, rd, addr, wdata} <= {w, ~w, a, 32'hFFFFFFFF};
        @(posedge ref_clk);
        {wr, rd} <= 2'h0;
        @(posedge ref_clk);
        d = rdata;
    endtask : bus
    // TMS bits taken LSB first; last 32 TDO samples kept
    task automatic run(input logic [35:0] m, input int n);
        for (int i = 0; i < n; i++) begin
            jm.step(m[i], tdi_hi | i[0], o);
            got = {o, got[31:1]};
        end
    endtask : run
    task automatic t_reset();
        chk({26'h0, core, emu, mv, mode, tdo_oe}, 32'h16);
        bus(1'b0, tpr_pkg::TPR_ID_ADDR);
        chk(d, {4'h0, id_up[27:0]});
        bus(1'b0, tpr_pkg::TPR_ID_ADDR + 32'h4);
        chk(d, 32'h0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_boot();
        dev_n <= 1'b1;
        run(36'h0, 3);
        bus(1'b1, tpr_pkg::TPR_ID_ADDR);
        bus(1'b0, tpr_pkg::TPR_ID_ADDR);
        chk(d, id_up);
        chk({30'h0, core, emu}, 32'h3);
        jm.pins(1'b1, 1'b0);
        run(36'h0, 3);
        chk({31'h0, emu}, 32'h1);
        $display("t_boot done");
    endtask : t_boot
    task automatic t_scan();
        msel <= 2'h2;
        jm.pins(1'b1, 1'b1);
        run(36'h0, 2);
        chk({29'h0, mv, mode}, 32'h6);
        run(36'h2, 35);
        chk(got, id_up);
        chk({31'h0, tdo_oe}, 32'h1);
        run(36'h1F, 5);
        chk({31'h0, emu}, 32'h0);
        $display("t_scan done");
    endtask : t_scan
    // IR load of all ones, then bypass: captures zero, passes data one stage late
    task automatic t_bypass();
        tdi_hi = 1'b1;
        run(36'h06, 8);
        chk({28'h0, got[31:28]}, {28'h0, tpr_pkg::TPR_IR_CAPT});
        run(36'h07, 7);
        chk({29'h0, got[31:29]}, 32'h6);
        $display("t_bypass done");
    endtask : t_bypass
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_boot();
        t_scan();
        t_bypass();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
